// File: hdl/spe_pkg.sv
// Constants, opcodes and parser states of the serial EEPROM command engine.
//
// Functional notes
// [R1] Write-enable latch: enable sets, disable clears.
// [R2] Enable/disable act on seventh edge; extras harmless. Code acts on the eighth rising edge (edge 7), at the opcode byte end.
// [R3] Host sends enable before any write command.
// [R4] Writes arriving with latch cleared are discarded.
// [R5] Executed write clears the write-enable latch.
// [R6] Latch comes up cleared after power-up.
// [R7] Read: opcode, address, data from falling fifteen.
// [R8] Read address auto-increments, wraps top to bottom.
// [R9] Select rise starts self-timed cycle, 4 ms.
// [R10] While programming only status read is accepted.
// [R11] Program only if select rises after byte end.
// [R12] Up to sixteen bytes programmed in one cycle.
// [R13] Page loading increments only low four address bits.
// [R14] Extra bytes overwrite earlier ones; final values programmed.
// [R15] Select rise off byte boundary cancels page write.
// [R16] Cancel keeps memory; unloaded page bytes unchanged.
// [R17] Sixteen-byte pages, pages 0 to 7, top 7Fh.
// [R18] Input sampled rising, output changed falling, MSB first.
// [R19] Eight-bit opcodes, upper nibble zero, bit 3 ignored.
// [R20] Status reports write-enable latch and busy flag.
// [R21] Serial output floats unless shifting read/status data.
package spe_pkg;

    // -----------------------------------------------------------------
    // Array geometry.
    // -----------------------------------------------------------------
    localparam int unsigned ADDR_W = 7;          // Byte address width, top address 7Fh.
    localparam int unsigned MEM_BYTES = 128;     // Number of bytes in the array.
    localparam int unsigned PAGE_BYTES = 16;     // Bytes in one page.
    localparam int unsigned PAGE_IDX_W = 4;      // Low address bits that walk within a page.
    localparam int unsigned PAGE_NUM_W = 3;      // High address bits that select the page.
    localparam logic [7:0] ERASED_BYTE = 8'hff;  // Contents of a fresh array.

    // -----------------------------------------------------------------
    // Opcodes: upper nibble zero, bit 3 ignored, low three bits decide.
    // -----------------------------------------------------------------
    localparam logic [3:0] OPC_UPPER = 4'h0;
    localparam logic [2:0] OPC_WRITE_ENABLE_CMD = 3'h6;      // write_enable_cmd.
    localparam logic [2:0] OPC_WRITE_DISABLE_CMD = 3'h4;      // write_disable_cmd.
    localparam logic [2:0] OPC_READ = 3'h3;      // Sequential read.
    localparam logic [2:0] OPC_WRITE = 3'h2;     // Byte or page write.
    localparam logic [2:0] OPC_RDSR = 3'h5;      // Status read.
    localparam logic [2:0] OPC_STATUS_WRITE_CMD = 3'h1;      // status_write_cmd.

    // -----------------------------------------------------------------
    // Status word layout.
    // -----------------------------------------------------------------
    localparam logic [3:0] STATUS_TOP = 4'hf;    // Bits 7..4 always read as one.
    localparam logic [1:0] STATUS_BP = 2'h0;     // Protect bits are not modelled.

    // -----------------------------------------------------------------
    // Serial framing.
    // -----------------------------------------------------------------
    localparam logic [2:0] BIT_LAST = 3'h7;      // Index of the last bit of a byte.
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // -----------------------------------------------------------------
    // Self-timed programming cycle.
    // -----------------------------------------------------------------
    localparam int unsigned PROG_TIME_US = 4000;             // program_cycle_time, 4 ms.
    localparam int unsigned SYS_CLK_MHZ = 250;               // System clock rate.
    localparam int unsigned PROG_CYCLES = PROG_TIME_US * SYS_CLK_MHZ;
    localparam int unsigned PROG_CNT_W = 20;                 // Holds PROG_CYCLES.

    // -----------------------------------------------------------------
    // Buffer of prefetched read bytes.
    // -----------------------------------------------------------------
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    // Command parser states.
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_RADDR = 3'b001,
        ST_WADDR = 3'b010,
        ST_RDATA = 3'b011,
        ST_WDATA = 3'b100,
        ST_SDATA = 3'b101,
        ST_STATUS = 3'b110,
        ST_IGNORE = 3'b111
    } spe_state_e;

endpackage

// File: hdl/spe_cmd_engine.sv
// Command engine of a 128-byte serial-bus EEPROM, device side.
`timescale 1ns/1ps

module spe_cmd_engine
    import spe_pkg::*;
#(
    parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
    // System clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Serial bus pins from the host.
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic sdi_i,
    // Serial data output pin, three-state.
    output logic sdo_o,
    output logic sdo_oe_o,
    // Device state, for observation.
    output logic busy_o,
    output logic write_enable_o
);

    // -----------------------------------------------------------------
    // Pin synchronisers and edge detection.
    // -----------------------------------------------------------------

    logic sck_m, sck_s, sck_d;      // Bus clock: first stage, second stage, delayed copy.
    logic cs_m, cs_s, cs_d;         // Chip select, same arrangement.
    logic si_m, si_s;               // Serial input, two stages.

    // Every pin passes two flip-flops; the third copy only serves edge finding.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {sck_m, sck_s, sck_d} <= 3'h0;
            {cs_m, cs_s, cs_d} <= 3'h7;
            {si_m, si_s} <= 2'h0;
        end else begin
            {sck_m, sck_s, sck_d} <= {sclk_i, sck_m, sck_s};
            {cs_m, cs_s, cs_d} <= {chip_select_n_i, cs_m, cs_s};
            {si_m, si_s} <= {sdi_i, si_m};
        end
    end

    wire cs_active = ~cs_s;                          // Chip select is low.
    wire sck_rise = sck_s & ~sck_d & cs_active;      // Sampling edge inside a frame.
    wire sck_fall = ~sck_s & sck_d & cs_active;      // Output edge inside a frame.
    wire cs_rise = cs_s & ~cs_d;                     // End of a frame.

    // -----------------------------------------------------------------
    // Opcode decoding.
    // -----------------------------------------------------------------

    // True when a byte is a given opcode; bit 3 is not looked at.
    function automatic logic opc_is(input logic [7:0] opc, input logic [2:0] low);
        opc_is = (opc[7:4] == OPC_UPPER) && (opc[2:0] == low); // [R19]
    endfunction

    // -----------------------------------------------------------------
    // Bit counter and input shifter.
    // -----------------------------------------------------------------

    spe_state_e state, next_state;  // Command parser state.
    logic [2:0] bit_idx;            // Bit position within the current byte.
    logic [6:0] shift_in;           // Bits of the current byte taken so far.
    logic wel;                      // Write-enable latch.
    logic busy;                     // Self-timed programming in progress.

    wire [7:0] rx_byte = {shift_in, si_s};                  // Byte completed by this edge.
    wire byte_end = sck_rise && (bit_idx == BIT_LAST);      // Edge that takes bit 0.

    // Input bits enter on the rising edge, most significant first.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_idx <= BIT_FIRST;
            shift_in <= 7'h00;
        end else if (!cs_active) begin
            bit_idx <= BIT_FIRST;   // Select high restarts the parse.
        end else if (sck_rise) begin
            bit_idx <= bit_idx + 3'h1;              // [R18]
            shift_in <= rx_byte[6:0];               // [R18]
        end
    end

    // -----------------------------------------------------------------
    // Command parser.
    // -----------------------------------------------------------------

    // Command decoding on the last opcode bit; bits are numbered from edge 0.
    wire op_write_enable_cmd = opc_is(rx_byte, OPC_WRITE_ENABLE_CMD);
    wire op_write_disable_cmd = opc_is(rx_byte, OPC_WRITE_DISABLE_CMD);
    wire op_read = opc_is(rx_byte, OPC_READ);
    wire op_write = opc_is(rx_byte, OPC_WRITE);
    wire op_rdsr = opc_is(rx_byte, OPC_RDSR);
    wire op_status_write_cmd = opc_is(rx_byte, OPC_STATUS_WRITE_CMD);
    wire opc_end = byte_end && (state == ST_OPCODE);

    // Next parser state, decided on the edge that ends each byte.
    always_comb begin
        next_state = state;
        case (state)
            ST_OPCODE: begin
                if (byte_end) begin
                    if (op_rdsr) begin
                        next_state = ST_STATUS;
                    end else if (busy) begin
                        next_state = ST_IGNORE;             // [R10]
                    end else if (op_read) begin
                        next_state = ST_RADDR;              // [R7]
                    end else if (op_write && wel) begin
                        next_state = ST_WADDR;
                    end else if (op_status_write_cmd && wel) begin
                        next_state = ST_SDATA;
                    end else begin
                        next_state = ST_IGNORE;             // [R4]
                    end
                end
            end
            ST_RADDR: begin
                if (byte_end) begin
                    next_state = ST_RDATA;
                end
            end
            ST_WADDR: begin
                if (byte_end) begin
                    next_state = ST_WDATA;
                end
            end
            default: begin
                next_state = state;     // Data and ignore states last the frame.
            end
        endcase
    end

    // State register; chip select high always returns to opcode parsing.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_OPCODE;
        end else if (!cs_active) begin
            state <= ST_OPCODE;
        end else begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------------
    // Write qualification and commit.
    // -----------------------------------------------------------------

    logic byte_done;    // Last rising edge completed a data byte.

    wire in_wdata = (state == ST_WDATA);
    wire in_sdata = (state == ST_SDATA);

    // Only a select rise right after a byte end is valid; any later rising edge clears it.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            byte_done <= 1'b0;
        end else if (!cs_active) begin
            byte_done <= 1'b0;
        end else if (sck_rise) begin
            byte_done <= byte_end && (in_wdata || in_sdata);  // [R11] [R15]
        end
    end

    wire commit_page = cs_rise && in_wdata && byte_done;   // [R9] [R11]
    wire commit_stat = cs_rise && in_sdata && byte_done;   // [R9]
    wire commit = commit_page || commit_stat;

    // -----------------------------------------------------------------
    // Write-enable latch.
    // -----------------------------------------------------------------

    // Reset gives the power-up value; enable and disable take effect at once.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wel <= 1'b0;                                // [R6]
        end else if (commit) begin
            wel <= 1'b0;                                // [R5]
        end else if (opc_end && !busy && op_write_enable_cmd) begin
            wel <= 1'b1;                                // [R1] [R2]
        end else if (opc_end && !busy && op_write_disable_cmd) begin
            wel <= 1'b0;                                // [R1] [R2]
        end
    end

    // -----------------------------------------------------------------
    // Page buffer.
    // -----------------------------------------------------------------

    logic [7:0] pg_data [PAGE_BYTES];       // Loaded data bytes.
    logic [PAGE_BYTES-1:0] pg_valid;        // Which page bytes were loaded.
    logic [PAGE_IDX_W-1:0] pg_ptr;          // Address within the page.
    logic [PAGE_NUM_W-1:0] pg_base;         // Page being loaded.

    wire page_start = byte_end && (state == ST_WADDR);
    wire page_store = byte_end && in_wdata;

    // Address byte opens the page; each data byte lands and steps the low bits.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pg_valid <= '0;
            pg_ptr <= '0;
            pg_base <= '0;
        end else if (page_start) begin
            pg_valid <= '0;                             // [R15] [R16]
            pg_base <= rx_byte[ADDR_W-1:PAGE_IDX_W];    // [R17]
            pg_ptr <= rx_byte[PAGE_IDX_W-1:0];
        end else if (page_store) begin
            pg_valid[pg_ptr] <= 1'b1;                   // [R12]
            pg_ptr <= pg_ptr + 4'h1;                    // [R13]
        end
    end

    // Byte storage; a later byte at the same slot replaces the earlier one.
    always_ff @(posedge sys_clk_i) begin
        if (page_store) begin
            pg_data[pg_ptr] <= rx_byte;                 // [R14]
        end
    end

    // -----------------------------------------------------------------
    // Memory array.
    // -----------------------------------------------------------------

    // Non-volatile array; it starts erased and reset leaves it alone.
    logic [7:0] mem [MEM_BYTES] = '{default: ERASED_BYTE};

    // A valid select rise writes every loaded byte of the page in one step.
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (commit_page && pg_valid[i]) begin
                mem[{pg_base, i[PAGE_IDX_W-1:0]}] <= pg_data[i];  // [R12] [R16]
            end
        end
    end

    // -----------------------------------------------------------------
    // Programming timer.
    // -----------------------------------------------------------------

    logic [PROG_CNT_W-1:0] prog_cnt;    // Cycles left of the programming time.

    // Busy is held for the whole programming time after a commit.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy <= 1'b0;
            prog_cnt <= '0;
        end else if (commit) begin
            busy <= 1'b1;                                       // [R9] [R20]
            prog_cnt <= PROG_CNT_W'(PROG_CYCLES_P - 1);
        end else if (busy) begin
            if (prog_cnt == '0) begin
                busy <= 1'b0;                                   // [R9]
            end else begin
                prog_cnt <= prog_cnt - PROG_CNT_W'(1);
            end
        end
    end

    // -----------------------------------------------------------------
    // Read prefetch buffer.
    // -----------------------------------------------------------------

    logic [ADDR_W-1:0] fetch_addr;  // Next address to fetch.
    logic [7:0] fifo_mem [2];       // Two prefetched bytes.
    logic fifo_wr, fifo_rd;         // Write and read pointers.
    logic [1:0] fifo_cnt;           // Bytes held.
    logic [2:0] out_left;           // Bits still to shift of the current byte.

    wire fill_valid = (state == ST_RDATA);              // Fetch side offers a byte.
    wire fill_ready = (fifo_cnt != FIFO_DEPTH);         // Buffer has room.
    wire push = fill_valid && fill_ready;
    wire drain_valid = (fifo_cnt != 2'h0);              // Buffer holds a byte.
    wire drain_ready = sck_fall && fill_valid && (out_left == BIT_FIRST);
    wire pop = drain_valid && drain_ready;

    // Fetch address loads from the address byte, then counts with natural wrap.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fetch_addr <= '0;
        end else if (byte_end && (state == ST_RADDR)) begin
            fetch_addr <= rx_byte[ADDR_W-1:0];          // [R7]
        end else if (push) begin
            fetch_addr <= fetch_addr + 7'h01;           // [R8]
        end
    end

    // Pointers and count; the buffer empties with the frame.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_wr <= 1'b0;
            fifo_rd <= 1'b0;
            fifo_cnt <= 2'h0;
        end else if (!fill_valid) begin
            fifo_wr <= 1'b0;
            fifo_rd <= 1'b0;
            fifo_cnt <= 2'h0;
        end else begin
            fifo_wr <= fifo_wr ^ push;
            fifo_rd <= fifo_rd ^ pop;
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // Buffer storage.
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            fifo_mem[fifo_wr] <= mem[fetch_addr];
        end
    end

    // -----------------------------------------------------------------
    // Output shifter.
    // -----------------------------------------------------------------

    logic [7:0] out_sh;     // Remaining bits, next one in bit 7.

    wire out_state = (state == ST_RDATA) || (state == ST_STATUS);
    wire [7:0] status_byte = {STATUS_TOP, STATUS_BP, wel, busy};       // [R20]
    wire [7:0] next_byte = (state == ST_STATUS) ? status_byte : fifo_mem[fifo_rd];
    wire shift_edge = sck_fall && out_state;

    // Bits leave on the falling edge, a fresh byte every eighth edge.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_sh <= 8'h00;
            out_left <= BIT_FIRST;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else if (!out_state) begin
            out_left <= BIT_FIRST;
            sdo_oe_o <= 1'b0;                           // [R21]
        end else if (shift_edge) begin
            sdo_oe_o <= 1'b1;                           // [R7]
            if (out_left == BIT_FIRST) begin
                sdo_o <= next_byte[7];                  // [R7] [R8] [R18]
                out_sh <= {next_byte[6:0], 1'b0};
                out_left <= BIT_LAST;
            end else begin
                sdo_o <= out_sh[7];                     // [R18]
                out_sh <= {out_sh[6:0], 1'b0};
                out_left <= out_left - 3'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Observation outputs.
    // -----------------------------------------------------------------

    // Registered copies of the latch and busy flag.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
            write_enable_o <= 1'b0;
        end else begin
            busy_o <= busy;
            write_enable_o <= wel;
        end
    end

endmodule

// File: dv/spe_host_model.sv
// Behavioural serial bus master in the host's place.
`timescale 1ns/1ps
module spe_host_model (
    // Serial bus pins toward the device.
    output logic sclk_o,
    output logic chip_select_n_o,
    output logic sdi_o,
    // Device output as seen on the wire, z when released.
    input wire logic sdo_i
);
    logic [7:0] tx_q[$]; // Bytes to send, opcode first.
    logic [7:0] rx_q[$]; // Whole bytes captured during the frame.
    // Idle bus: clock low, device not selected.
    initial begin
        sclk_o = 1'b0;
        chip_select_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // One frame of nbits clocks, 160 ns period; a partial byte is sent as is.
    task automatic run(input int nbits);
        logic [7:0] sh;
        rx_q = {};
        chip_select_n_o = 1'b0;
        #40;
        for (int i = 0; i < nbits; i++) begin
            // Bits past the queue toggle so the device sees no held value.
            sdi_o = (i / 8 < tx_q.size()) ? tx_q[i / 8][7 - i % 8] : ~sdi_o;
            #40;
            sclk_o = 1'b1;
            sh = {sh[6:0], sdo_i};
            if (i % 8 == 7) rx_q.push_back(sh);
            #80;
            sclk_o = 1'b0;
            #40;
        end
        #40;
        chip_select_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #200;
    endtask
endmodule

// File: dv/spe_cmd_engine_checker.sv
// Port-level assertions of the command engine.
`timescale 1ns/1ps
module spe_cmd_engine_checker #(
    parameter int unsigned PROG_CYCLES_P = 200
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Serial pins.
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    // Device state.
    input wire logic busy_o,
    input wire logic write_enable_o
);
    int unsigned busy_cnt; // Cycles that busy has been high so far.
    // Measures each programming cycle.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_busy_len;
        $fell(busy_o) |-> busy_cnt >= PROG_CYCLES_P && busy_cnt <= PROG_CYCLES_P + 2;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("programming cycle length wrong");
    property p_busy_max;
        busy_o |-> busy_cnt <= PROG_CYCLES_P + 2;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("programming cycle too long");
    property p_wel_clr;
        $rose(busy_o) |-> ##[0:2] !write_enable_o;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch kept after write");
    property p_wel_need;
        $rose(busy_o) |-> $past(write_enable_o) || $past(write_enable_o, 2);
    endproperty
    a_wel_need: assert property (p_wel_need) else $error("write ran with latch clear");
    property p_wel_busy;
        busy_o && $past(busy_o, 3) |-> $stable(write_enable_o);
    endproperty
    a_wel_busy: assert property (p_wel_busy) else $error("latch moved while busy");
    property p_wel_set;
        $rose(write_enable_o) |-> !$past(chip_select_n_i, 6);
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch set outside a frame");
    property p_oe_cs;
        chip_select_n_i [*8] |-> !sdo_oe_o;
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
    property p_oe_start;
        $rose(sdo_oe_o) |-> !sclk_i && !chip_select_n_i;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("output started off a falling edge");
    property p_sdo_fall;
        sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> !sclk_i && !$past(sclk_i);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("output changed while clock high");
    c_busy: cover property ($rose(busy_o));
    c_oe: cover property ($rose(sdo_oe_o));
    c_wel: cover property ($rose(write_enable_o));
endmodule
bind spe_cmd_engine spe_cmd_engine_checker #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .busy_o(busy_o), .write_enable_o(write_enable_o));

// File: dv/spe_cmd_engine_tb.sv
// Self-checking testbench of the serial EEPROM command engine.
`timescale 1ns/1ps
module spe_cmd_engine_tb
    import spe_pkg::*;
;
    localparam int unsigned PROG_N = 2000; // Shortened programming cycle.
    logic sys_clk_i;
    logic sys_rst_i;
    wire logic sclk;
    wire logic cs_n;
    wire logic sdi;
    wire logic sdo_line; // Output pin level, z when released.
    logic sdo;
    logic sdo_oe;
    logic busy;
    logic wel;
    int error_cnt = 0;
    int n_compared = 0;
    logic [7:0] shadow [0:127]; // Expected array contents.
    assign sdo_line = sdo_oe ? sdo : 1'bz;
    spe_cmd_engine #(.PROG_CYCLES_P(PROG_N)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .chip_select_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .busy_o(busy), .write_enable_o(wel));
    spe_host_model host (.sclk_o(sclk), .chip_select_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line));
    // Free-running system clock.
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic close_out();
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int nbits);
        host.tx_q = '{op};
        host.run(nbits);
    endtask
    task automatic stat(input logic [7:0] exp);
        cmd(8'h05, 16);
        chk("status", exp, host.rx_q[1]);
    endtask
    // Write n bytes from base upward; the shadow follows only a committed write.
    task automatic wr(input logic [6:0] a, input int n, input int extra, input logic [7:0] base, input bit ok);
        host.tx_q = '{8'h02, {1'b0, a}};
        for (int k = 0; k < n; k++) host.tx_q.push_back(8'(base + k));
        host.run(8 * (n + 2) + extra);
        if (ok) for (int k = 0; k < n; k++) shadow[{a[6:4], 4'(a[3:0] + k)}] = 8'(base + k);
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        host.tx_q = '{8'h03, {1'b0, a}};
        host.run(8 * (n + 2));
        chk("released output", 8'hzz, host.rx_q[1]);
        for (int k = 0; k < n; k++) chk("read data", shadow[7'(a + k)], host.rx_q[k + 2]);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < PROG_N + 100 && busy !== 1'b0; i++) @(posedge sys_clk_i);
        #1;
        chk("busy end", 8'h00, {7'h0, busy});
    endtask
    task automatic t_enable();
        chk("latch at reset", 8'h00, {7'h0, wel});
        cmd(8'h06, 7);
        chk("latch short frame", 8'h00, {7'h0, wel});
        cmd(8'h0e, 12);
        chk("latch set", 8'h01, {7'h0, wel});
        cmd(8'h04, 8);
        chk("latch cleared", 8'h00, {7'h0, wel});
        wr(7'h40, 1, 0, 8'h11, 1'b0);
        chk("busy no latch", 8'h00, {7'h0, busy});
    endtask
    task automatic t_page();
        cmd(8'h06, 8);
        wr(7'h1e, 18, 0, 8'h20, 1'b1);
        chk("busy page", 8'h01, {7'h0, busy});
        chk("latch after write", 8'h00, {7'h0, wel});
        cmd(8'h06, 8);
        stat(8'hf1);
        wait_idle();
        chk("latch after busy", 8'h00, {7'h0, wel});
        rd(7'h0f, 18);
    endtask
    task automatic t_cancel();
        cmd(8'h06, 8);
        stat(8'hf2);
        wr(7'h40, 2, 3, 8'h33, 1'b0);
        chk("busy cancel", 8'h00, {7'h0, busy});
        chk("latch cancel", 8'h01, {7'h0, wel});
        rd(7'h40, 2);
        wr(7'h7f, 1, 0, 8'h5a, 1'b1);
        wait_idle();
        rd(7'h7e, 3);
    endtask
    // Status write: refused with the latch clear, else one byte starts a programming cycle.
    task automatic t_stwrite();
        cmd(8'h01, 16);
        chk("busy status write no latch", 8'h00, {7'h0, busy});
        cmd(8'h06, 8);
        host.tx_q = '{8'h01, 8'h0c};
        host.run(16);
        chk("busy status write", 8'h01, {7'h0, busy});
        chk("latch status write", 8'h00, {7'h0, wel});
        stat(8'hf1);
        wait_idle();
    endtask
    // Watchdog against a hung handshake.
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
    initial begin
        sys_rst_i = 1'b1;
        for (int i = 0; i < 128; i++) shadow[i] = ERASED_BYTE;
        repeat (6) @(posedge sys_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        #1;
        t_enable();
        t_page();
        t_cancel();
        t_stwrite();
        close_out();
    end
endmodule
